/* File: hdl/isfd_desc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface isfd_desc_if;
   logic [63:0] word;
   logic valid;
   logic token_legal;
   logic token_in;
   logic split_sel;
   logic [6:0] function_addr;
   logic [3:0] endpoint_num;
   logic [10:0] split_chunk_limit;
   logic [14:0] total_byte_count;
   modport owner (output word, input valid, token_legal, token_in, split_sel,
                  function_addr, endpoint_num, split_chunk_limit, total_byte_count);
   modport decoder (input word, output valid, token_legal, token_in, split_sel,
                    function_addr, endpoint_num, split_chunk_limit, total_byte_count);
endinterface : isfd_desc_if
`default_nettype wire

/* File: hdl/isfd_field_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module isfd_field_decode
   import isfd_pkg::*;
(
   // descriptor in, fields out
   isfd_desc_if.decoder d
);
   logic [1:0] token;

   // pure field extraction; bits 30:29 and 2:1 are never looked at [R12]
   assign token = d.word[ISFD_TOKEN_MSB:ISFD_TOKEN_LSB];
   assign d.valid = d.word[ISFD_VALID_BIT];
   assign d.token_legal = (token == ISFD_TOKEN_OUT) || (token == ISFD_TOKEN_IN); // [R1]
   assign d.token_in = (token == ISFD_TOKEN_IN); // [R1]
   assign d.split_sel = d.word[ISFD_SPLIT_BIT]; // [R11]
   assign d.function_addr = d.word[ISFD_ADDR_MSB:ISFD_ADDR_LSB]; // [R2]
   assign d.endpoint_num = {d.word[ISFD_EP_HIGH_MSB:ISFD_EP_HIGH_LSB],
                            d.word[ISFD_EP_LOW_BIT]}; // [R3]
   assign d.split_chunk_limit = d.word[ISFD_CHUNK_MSB:ISFD_CHUNK_LSB]; // [R4]
   assign d.total_byte_count = d.word[ISFD_TOTAL_MSB:ISFD_TOTAL_LSB]; // [R7]
endmodule : isfd_field_decode
`default_nettype wire

/* File: hdl/isfd_pkg.sv */
package isfd_pkg;
   // register byte offsets on the apb side
   localparam logic [7:0] ISFD_ADDR_DESC_LO = 8'h00;
   localparam logic [7:0] ISFD_ADDR_DESC_HI = 8'h04;
   localparam logic [7:0] ISFD_ADDR_STATUS = 8'h08;
   localparam logic [7:0] ISFD_ADDR_PROGRESS = 8'h0C;
   localparam logic [31:0] ISFD_RESET_WORD = 32'h0000_0000;
   // field positions inside the 64-bit descriptor word
   localparam int ISFD_VALID_BIT = 0;
   localparam int ISFD_TOTAL_LSB = 3;
   localparam int ISFD_TOTAL_MSB = 17;
   localparam int ISFD_CHUNK_LSB = 18;
   localparam int ISFD_CHUNK_MSB = 28;
   localparam int ISFD_EP_LOW_BIT = 31;
   localparam int ISFD_EP_HIGH_LSB = 32;
   localparam int ISFD_EP_HIGH_MSB = 34;
   localparam int ISFD_ADDR_LSB = 35;
   localparam int ISFD_ADDR_MSB = 41;
   localparam int ISFD_TOKEN_LSB = 42;
   localparam int ISFD_TOKEN_MSB = 43;
   localparam int ISFD_SPLIT_BIT = 46;
   // token encodings
   localparam logic [1:0] ISFD_TOKEN_OUT = 2'h0;
   localparam logic [1:0] ISFD_TOKEN_IN = 2'h1;
   // status word layout
   localparam int ISFD_ST_BUSY_BIT = 0;
   localparam int ISFD_ST_FATAL_BIT = 1;
   localparam int ISFD_ST_DONE_BIT = 2;
   // executor states, gray along idle-issue-wait-finish
   typedef enum logic [1:0] {
      ISFD_IDLE = 2'h0,
      ISFD_ISSUE = 2'h1,
      ISFD_WAIT = 2'h3,
      ISFD_FINISH = 2'h2
   } isfd_state_t;
endpackage : isfd_pkg

/* File: hdl/isfd_split_exec.sv */
// What this block does
// R1: token 00 issues an OUT transaction, 01 issues an IN transaction.
// R2: function address comes from descriptor bits 41 down to 35.
// R3: endpoint is bits 34:32 as upper three bits, bit 31 as lowest.
// R4: each start split carries at most the limit in bits 28 down to 18.
// R5: software sets limit 188 OUT, 192 IN, else equal to total bytes.
// R6: software puts total byte count in bits 17:3, at most 1023.
// R7: total byte count acts as downstream maximum packet size.
// R8: software sets validity bit 0 when payload is pending.
// R9: hardware clears validity bit after full execution or a fatal error.
// R10: software mirrors validity into upper active flag; hardware clears it later. This block never clears bit 63.
// R11: split-select 1 runs split transactions, 0 a plain high-speed one.
// R12: reserved bits 30:29 and 2:1 written zero, ignored by hardware.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module isfd_split_exec
   import isfd_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transaction request toward the bus engine
   output logic req_valid,
   output logic req_in,
   output logic req_split,
   output logic [6:0] req_addr,
   output logic [3:0] req_ep,
   output logic [14:0] req_len,
   // answer from the bus engine, same clock
   input wire logic link_done,
   input wire logic [14:0] link_bytes,
   input wire logic link_fatal
);
   isfd_desc_if d ();
   isfd_state_t st_r;
   logic [31:0] desc_lo_r;
   logic [31:0] desc_hi_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic req_valid_r;
   logic req_in_r;
   logic req_split_r;
   logic [6:0] req_addr_r;
   logic [3:0] req_ep_r;
   logic [14:0] req_len_r;
   logic [14:0] remain_r;
   logic [14:0] moved_r;
   logic [10:0] chunk_r;
   logic fatal_r;
   logic done_r;
   logic clr_valid;
   logic set_fatal;
   logic set_done;
   logic go;
   logic access;
   logic commit;
   logic mapped;
   logic wr_lo;
   logic wr_hi;
   logic wr_status;
   logic [14:0] got;
   logic [14:0] remain_nxt;
   logic [14:0] len_nxt;

   isfd_field_decode u_decode (
      .d(d.decoder)
   );

   assign d.word = {desc_hi_r, desc_lo_r};

   // apb decode; writes land only on the completing access edge
   assign access = psel && penable;
   assign commit = access && pready_r;
   assign mapped = (paddr == ISFD_ADDR_DESC_LO) || (paddr == ISFD_ADDR_DESC_HI) ||
                   (paddr == ISFD_ADDR_STATUS) || (paddr == ISFD_ADDR_PROGRESS);
   assign wr_lo = commit && pwrite && (paddr == ISFD_ADDR_DESC_LO);
   assign wr_hi = commit && pwrite && (paddr == ISFD_ADDR_DESC_HI);
   assign wr_status = commit && pwrite && (paddr == ISFD_ADDR_STATUS);

   // one wait state on every access so read data can come from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= access && !pready_r;
         pslverr_r <= access && !pready_r && !mapped;
      end
   end

   // read mux registered during the wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= ISFD_RESET_WORD;
      end else if (access && !pready_r && !pwrite) begin
         case (paddr)
            ISFD_ADDR_DESC_LO: prdata_r <= desc_lo_r;
            ISFD_ADDR_DESC_HI: prdata_r <= desc_hi_r;
            ISFD_ADDR_STATUS: begin
               prdata_r <= ISFD_RESET_WORD;
               prdata_r[ISFD_ST_BUSY_BIT] <= (st_r != ISFD_IDLE);
               prdata_r[ISFD_ST_FATAL_BIT] <= fatal_r;
               prdata_r[ISFD_ST_DONE_BIT] <= done_r;
            end
            ISFD_ADDR_PROGRESS: prdata_r <= {17'h0_0000, moved_r};
            default: prdata_r <= ISFD_RESET_WORD;
         endcase
      end
   end

   // descriptor words; a software write in the clear cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_lo_r <= ISFD_RESET_WORD;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr_lo && pstrb[b]) begin
               desc_lo_r[b*8 +: 8] <= pwdata[b*8 +: 8];
            end
         end
         if (clr_valid && !(wr_lo && pstrb[0])) begin
            desc_lo_r[ISFD_VALID_BIT] <= 1'b0; // [R9]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_hi_r <= ISFD_RESET_WORD;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr_hi && pstrb[b]) begin
               desc_hi_r[b*8 +: 8] <= pwdata[b*8 +: 8];
            end
         end
      end
   end

   // sticky outcome flags, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fatal_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         fatal_r <= set_fatal || (fatal_r && !(wr_status && pstrb[0] &&
                                  pwdata[ISFD_ST_FATAL_BIT]));
         done_r <= set_done || (done_r && !(wr_status && pstrb[0] &&
                                pwdata[ISFD_ST_DONE_BIT]));
      end
   end

   // a zero limit in split mode could never make progress, so it is fatal
   assign go = (st_r == ISFD_IDLE) && d.valid;
   assign got = (link_bytes > req_len_r) ? req_len_r : link_bytes;
   assign remain_nxt = remain_r - got;
   assign len_nxt = (req_split_r && ({4'h0, chunk_r} < remain_r)) ?
                    {4'h0, chunk_r} : remain_r; // [R4]

   // hardware clears validity on completion or on any fatal condition
   always_comb begin
      clr_valid = 1'b0;
      set_fatal = 1'b0;
      set_done = 1'b0;
      if (go && (!d.token_legal || (d.split_sel && d.split_chunk_limit == 11'h000))) begin
         clr_valid = 1'b1; // [R9]
         set_fatal = 1'b1;
      end else if (go && d.total_byte_count == 15'h0000) begin
         clr_valid = 1'b1; // [R9]
         set_done = 1'b1;
      end else if (st_r == ISFD_WAIT && link_done && link_fatal) begin
         clr_valid = 1'b1; // [R9]
         set_fatal = 1'b1;
      end else if (st_r == ISFD_FINISH) begin
         clr_valid = 1'b1; // [R9]
         set_done = 1'b1;
      end
   end

   // executor: start splits until the total is moved, or one plain transaction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ISFD_IDLE;
      end else begin
         case (st_r)
            ISFD_IDLE: if (go && !clr_valid) st_r <= ISFD_ISSUE;
            ISFD_ISSUE: st_r <= ISFD_WAIT;
            ISFD_WAIT: begin
               if (link_done && link_fatal) begin
                  st_r <= ISFD_IDLE;
               end else if (link_done) begin
                  // a short packet or plain transaction ends the descriptor
                  if (!req_split_r || remain_nxt == 15'h0000 || got < req_len_r) begin
                     st_r <= ISFD_FINISH; // [R11]
                  end else begin
                     st_r <= ISFD_ISSUE;
                  end
               end
            end
            ISFD_FINISH: st_r <= ISFD_IDLE;
            default: st_r <= ISFD_IDLE;
         endcase
      end
   end

   // fields are latched at start so later descriptor writes cannot tear a run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_in_r <= 1'b0;
         req_split_r <= 1'b0;
         req_addr_r <= 7'h00;
         req_ep_r <= 4'h0;
         chunk_r <= 11'h000;
      end else if (go && !clr_valid) begin
         req_in_r <= d.token_in; // [R1]
         req_split_r <= d.split_sel; // [R11]
         req_addr_r <= d.function_addr; // [R2]
         req_ep_r <= d.endpoint_num; // [R3]
         chunk_r <= d.split_chunk_limit; // [R4]
      end
   end

   // byte accounting; the total is the ceiling for the whole run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain_r <= 15'h0000;
         moved_r <= 15'h0000;
      end else if (go) begin
         // a refused or empty run still restarts the progress count at zero
         remain_r <= d.total_byte_count; // [R7]
         moved_r <= 15'h0000;
      end else if (st_r == ISFD_WAIT && link_done && !link_fatal) begin
         remain_r <= remain_nxt;
         moved_r <= moved_r + got;
      end
   end

   // request held until the engine answers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_valid_r <= 1'b0;
         req_len_r <= 15'h0000;
      end else if (st_r == ISFD_ISSUE) begin
         req_valid_r <= 1'b1;
         req_len_r <= len_nxt; // [R4] [R7]
      end else if (st_r == ISFD_WAIT && link_done) begin
         req_valid_r <= 1'b0;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign req_valid = req_valid_r;
   assign req_in = req_in_r;
   assign req_split = req_split_r;
   assign req_addr = req_addr_r;
   assign req_ep = req_ep_r;
   assign req_len = req_len_r;

   // checks on the driven behaviour
   a_token_direction: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      (go && !clr_valid) |=> (req_in_r == $past(d.token_in)))
      else $error("token direction not latched");
   a_addr_capture: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (go && !clr_valid) |=> ##1 (req_valid_r && req_addr_r == $past(d.function_addr, 2)))
      else $error("function address mismatch");
   a_ep_assembly: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (go && !clr_valid) |=> (req_ep_r == {$past(desc_hi_r[2:0]), $past(desc_lo_r[31])}))
      else $error("endpoint assembly wrong");
   a_chunk_bound: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (req_valid_r && req_split_r) |-> (req_len_r <= {4'h0, chunk_r} && req_len_r != 15'h0000))
      else $error("split payload exceeds limit");
   a_plain_whole: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (req_valid_r && !req_split_r) |-> (req_len_r == remain_r))
      else $error("plain transaction not whole count");
   a_finish_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (st_r == ISFD_FINISH && !wr_lo) |=> (!desc_lo_r[ISFD_VALID_BIT] && st_r == ISFD_IDLE))
      else $error("valid not cleared at finish");
   a_fatal_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (st_r == ISFD_WAIT && link_done && link_fatal && !wr_lo) |=>
      (!desc_lo_r[ISFD_VALID_BIT] && fatal_r && !req_valid_r))
      else $error("fatal did not clear valid");
   a_plain_single: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (st_r == ISFD_WAIT && link_done && !link_fatal && !req_split_r) |=> (st_r == ISFD_FINISH))
      else $error("plain transaction repeated");
   a_refuse_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (go && !d.token_legal && !wr_lo) |=>
      (!desc_lo_r[ISFD_VALID_BIT] && fatal_r && st_r == ISFD_IDLE))
      else $error("refused descriptor left active");
   a_moved_restart: assert property (@(posedge pclk) disable iff (!presetn)
      go |=> (moved_r == 15'h0000))
      else $error("byte progress not restarted");
   a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready_r) |=> (pready_r && (pslverr_r == !$past(mapped))))
      else $error("apb answer timing wrong");
endmodule : isfd_split_exec
`default_nettype wire

/* File: sim/isfd_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module isfd_engine_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from the block
   input wire logic req_valid,
   input wire logic [14:0] req_len,
   // behaviour set by the bench
   input wire logic [3:0] dly,
   input wire logic fail_mode,
   input wire logic [14:0] cap,
   // answer toward the block
   output logic link_done,
   output logic [14:0] link_bytes,
   output logic link_fatal
);
   logic [3:0] cnt_r;
   logic served_r;
   // one answer per request after a programmable stall; byte lines toggle when meaningless
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         served_r <= 1'b0;
         link_done <= 1'b0;
         link_fatal <= 1'b0;
         link_bytes <= 15'h0000;
      end else begin
         link_done <= 1'b0;
         link_fatal <= 1'b0;
         link_bytes <= ~link_bytes;
         if (!req_valid) begin
            served_r <= 1'b0;
            cnt_r <= 4'h0;
         end else if (!served_r) begin
            if (cnt_r == dly) begin
               link_done <= 1'b1;
               link_fatal <= fail_mode;
               link_bytes <= (req_len < cap) ? req_len : cap; // never more than asked
               served_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 4'h1;
            end
         end
      end
   end
endmodule : isfd_engine_model
`default_nettype wire

/* File: sim/isfd_split_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module isfd_split_exec_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, req_valid, req_in, req_split, link_done, link_fatal;
   logic [6:0] req_addr;
   logic [3:0] req_ep;
   logic [14:0] req_len, link_bytes;
   logic [3:0] dly = 4'h0;
   logic fail_mode = 1'b0;
   logic [14:0] cap = 15'h7FFF;
   logic rv_prev = 1'b0;
   logic [27:0] q[$];
   int n_fail = 0;
   int n_tests = 0;
   // half period of 4 ns gives 125 MHz
   always #4 pclk = ~pclk;
   isfd_split_exec i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_in(req_in),
      .req_split(req_split), .req_addr(req_addr), .req_ep(req_ep), .req_len(req_len),
      .link_done(link_done), .link_bytes(link_bytes), .link_fatal(link_fatal));
   isfd_engine_model i_eng (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
      .req_len(req_len), .dly(dly), .fail_mode(fail_mode), .cap(cap), .link_done(link_done),
      .link_bytes(link_bytes), .link_fatal(link_fatal));
   // log every new request with all its fields
   always @(posedge pclk) begin
      if (req_valid === 1'b1 && rv_prev !== 1'b1)
         q.push_back({req_in, req_split, req_addr, req_ep, req_len});
      rv_prev <= req_valid;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int k;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (k >= 50) begin
         n_fail++;
         tally_and_finish();
      end
   endtask : apb
   // byte strobes gate descriptor writes lane by lane
   task automatic strobe_lanes;
      logic [31:0] rd;
      logic er;
      apb(8'h04, 1'b1, 32'h0000_0000, rd, er);
      pstrb <= 4'h2;
      apb(8'h04, 1'b1, 32'hFFFF_FFFF, rd, er);
      pstrb <= 4'hF;
      apb(8'h04, 1'b0, 32'h0000_0000, rd, er);
      chk("strobe lanes", 32'h0000_FF00, rd);
      $display("test strobe done");
   endtask : strobe_lanes
   // load one descriptor, let it run, then judge requests, status, count and valid bit
   task automatic run(input string nm, input logic [1:0] tok, input logic sp,
      input logic [10:0] lim, input logic [14:0] tot, input logic fm, input logic [14:0] cp);
      logic [63:0] d;
      logic [31:0] rd;
      logic [31:0] ex;
      logic er, fe, bz;
      logic [14:0] rem, l, moved;
      int n, k;
      d = 64'h0000_0000_0000_0000;
      d[63] = 1'b1; // active flag mirrors the validity bit
      d[46] = sp;
      d[43:42] = tok;
      d[41:35] = 7'h55;
      d[34:32] = 3'h5;
      d[31] = 1'b1;
      d[30:29] = 2'h3; // reserved bits set to show they are ignored
      d[28:18] = lim;
      d[17:3] = tot;
      d[2:1] = 2'h3;
      d[0] = 1'b1; // payload pending marks the descriptor active
      bz = 1'b0;
      fail_mode <= fm;
      cap <= cp;
      q.delete();
      apb(8'h04, 1'b1, d[63:32], rd, er);
      apb(8'h00, 1'b1, d[31:0], rd, er);
      k = 0;
      do begin
         apb(8'h08, 1'b0, 32'h0000_0000, rd, er);
         if (k == 0) bz = rd[0];
         k++;
      end while (rd[2:1] === 2'b00 && k < 60);
      if (k >= 60) begin
         n_fail++;
         tally_and_finish();
      end
      fe = (tok > 2'h1) || (sp && lim == 11'h000);
      // an accepted run with a nonzero total is still busy when the first status read is taken
      chk({nm, " busy"}, {31'h0, !fe && tot != 15'h0000}, {31'h0, bz});
      rem = fe ? 15'h0000 : tot;
      moved = 15'h0000;
      n = 0;
      while (rem != 15'h0000) begin
         l = (sp && rem > 15'(lim)) ? 15'(lim) : rem;
         ex = {4'h0, tok[0], sp, 7'h55, 4'hB, l};
         if (n < q.size()) chk({nm, " request"}, ex, {4'h0, q[n]});
         n++;
         moved += (l < cp) ? l : cp;
         fe = fm;
         if (fm || cp < l) rem = 15'h0000;
         else rem -= l;
      end
      chk({nm, " count"}, 32'(n), 32'(q.size()));
      chk({nm, " status"}, {29'h0, ~fe, fe, 1'b0}, rd);
      if (!fe) begin
         apb(8'h0C, 1'b0, 32'h0000_0000, rd, er);
         chk({nm, " moved"}, {17'h0, moved}, rd);
      end
      apb(8'h00, 1'b0, 32'h0000_0000, rd, er);
      chk({nm, " valid"}, 32'h0000_0000, {31'h0, rd[0]});
      apb(8'h08, 1'b1, 32'h0000_0007, rd, er);
      $display("test %s done", nm);
   endtask : run
   initial begin
      logic [31:0] rd;
      logic er;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         apb(8'(i * 4), 1'b0, 32'h0000_0000, rd, er);
         chk("reset read", 32'h0000_0000, rd);
         chk("error flag", (i == 4) ? 32'h0000_0001 : 32'h0000_0000, {31'h0, er});
      end
      $display("test reset done");
      strobe_lanes();
      run("out split", 2'h0, 1'b1, 11'd188, 15'd400, 1'b0, 15'h7FFF);
      dly <= 4'h6;
      run("in split", 2'h1, 1'b1, 11'd192, 15'd192, 1'b0, 15'h7FFF);
      run("in plain", 2'h1, 1'b0, 11'd5, 15'd1023, 1'b0, 15'h7FFF);
      dly <= 4'h0;
      run("short", 2'h1, 1'b1, 11'd192, 15'd400, 1'b0, 15'd100);
      run("zero total", 2'h0, 1'b1, 11'd188, 15'd0, 1'b0, 15'h7FFF);
      run("bad token", 2'h2, 1'b1, 11'd188, 15'd400, 1'b0, 15'h7FFF);
      run("zero limit", 2'h0, 1'b1, 11'd0, 15'd400, 1'b0, 15'h7FFF);
      run("link fatal", 2'h0, 1'b1, 11'd188, 15'd400, 1'b1, 15'h7FFF);
      tally_and_finish();
   end
endmodule : isfd_split_exec_tb_top
`default_nettype wire
